// ---- common/acqfl_regs.vh ----
`ifndef ACQFL_REGS_VH
`define ACQFL_REGS_VH

// -----------------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------------
`define ACQFL_IDX_AVAIL_COUNT   16'h00c8
`define ACQFL_IDX_AVAIL_INDEX   16'h00c9
`define ACQFL_IDX_CARD_RELEASE  16'h00ca
`define ACQFL_IDX_FILL_PERMILLE 16'h00cb
`define ACQFL_IDX_RECORD_LEN    16'h0100
`define ACQFL_IDX_POST_LEN      16'h0101
`define ACQFL_IDX_PRE_LEN       16'h0102
`define ACQFL_IDX_SEG_LEN       16'h0103
`define ACQFL_IDX_SEG_COUNT     16'h0104
`define ACQFL_IDX_CONFIG        16'h0105
`define ACQFL_IDX_BUF_LEN       16'h0106
`define ACQFL_IDX_STATUS        16'h0107

// -----------------------------------------------------------------------
// Config fields
// -----------------------------------------------------------------------
`define ACQFL_CFG_STREAM_BIT    0
`define ACQFL_CFG_TO_DEV_BIT    1
`define ACQFL_CFG_CH_LSB        4
`define ACQFL_CFG_CH_MSB        5

// -----------------------------------------------------------------------
// Limits in samples per channel, then sample size and fill constants
// -----------------------------------------------------------------------
`define ACQFL_STEP_MASK         64'h0000_0000_0000_0003
`define ACQFL_MIN_RECORD        64'h0000_0000_0000_0008
`define ACQFL_MIN_PRE           64'h0000_0000_0000_0004
`define ACQFL_MIN_POST          64'h0000_0000_0000_0004
`define ACQFL_MIN_SEG           64'h0000_0000_0000_0008
`define ACQFL_MAX_STREAM        64'h0000_0001_ffff_fffc
`define ACQFL_PRE_MAX_1CH       64'h0000_0000_0000_1ff0
`define ACQFL_PRE_MAX_2CH       64'h0000_0000_0000_0ff8
`define ACQFL_PRE_MAX_4CH       64'h0000_0000_0000_07fc
`define ACQFL_PRE_MAX_8CH       64'h0000_0000_0000_03fc
`define ACQFL_BYTES_PER_SAMPLE  64'h0000_0000_0000_0002
`define ACQFL_PERMILLE_STEP     10'h03f
`define ACQFL_PERMILLE_FULL     10'h3e8
`define ACQFL_FILL_SIXTEENTHS   4

`endif

// ---- core/acqfl_sample_mem.v ----
`timescale 1ns/1ps
`default_nettype none

module acqfl_sample_mem #(
  parameter AW = 10,
  parameter DW = 16
) (
  // Clock
  input  wire          i_ref_clk,
  // Write port
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [DW-1:0] i_wr_data,
  // Read port
  input  wire [AW-1:0] i_rd_addr,
  output reg  [DW-1:0] o_rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end

endmodule

`default_nettype wire

// ---- core/acqfl_core.v ----
`timescale 1ns/1ps
`default_nettype none
`include "acqfl_regs.vh"

// How it works
// - Record length fixed before start, stream optional
// - Two bytes per sample, max memory over channels
// - Maximum record and pre-event lengths depend on channels
// - Pre-event limits per channel count enforced in streaming mode
// - Post, segment minimums and stream maximum checked
// - Memory term scales with installed size parameter
// - Whole sample memory serves as streaming FIFO
// - Transfer engine moves words without host help
// - User and card byte counters kept internally
// - Index 200 reads bytes available to application
// - Index 201 reads start of available region
// - Index 202 write returns bytes to engine
// - Toward-device bit is only stored; available still means filled bytes
// - From device, available means filled bytes
// - Fill reported in permille, sixteenth steps
// - Memory mode derives pre-event as record minus post-event
// - Zero segment count streams until stopped
// - Start clears user count, card gets buffer
module acqfl_core #(
  parameter MEM_AW     = 10,
  parameter MEM_SAMPLES = 64'h0000_0000_0200_0000
) (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // Register port
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [15:0] i_reg_idx,
  input  wire [63:0] i_reg_wdata,
  output reg  [63:0] o_reg_rdata,
  output reg         o_reg_rvalid,
  // Control
  input  wire        i_start,
  input  wire        i_stop,
  // Sample input
  input  wire        i_smp_valid,
  input  wire [15:0] i_smp_data,
  output wire        o_smp_ready,
  // Host DMA side
  output wire        o_dma_valid,
  output reg  [15:0] o_dma_data,
  input  wire        i_dma_ready,
  // Status
  output reg         o_running,
  output reg         o_cfg_error,
  output reg         o_overrun
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function [63:0] mem_per_ch;
    input [63:0] mem;
    input [1:0]  ch;
    begin
      mem_per_ch = mem >> ch;
    end
  endfunction

  function len_ok;
    input [63:0] v;
    input [63:0] lo;
    input [63:0] hi;
    begin
      len_ok = (v >= lo) && (v <= hi) && ((v & `ACQFL_STEP_MASK) == 64'h0);
    end
  endfunction

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  reg [63:0] record_length;
  reg [63:0] post_event_length;
  reg [63:0] pre_event_length;
  reg [63:0] segment_length;
  reg [63:0] segment_count;
  reg [63:0] buf_len;
  reg        streaming_single_mode;
  reg        to_device;
  reg [1:0]  ch_log2;

  reg [63:0] host_avail_byte_count;
  reg [63:0] host_avail_byte_index;
  reg [63:0] card_bytes;
  reg [63:0] done_samples;
  reg [63:0] seg_samples;
  reg [63:0] seg_done;

  wire [63:0] max_record = mem_per_ch(MEM_SAMPLES, ch_log2);
  reg  [63:0] pre_max;
  wire [63:0] derived_pre = record_length - post_event_length;
  wire        cfg_ok;

  always @* begin
    case (ch_log2)
      2'd0:    pre_max = `ACQFL_PRE_MAX_1CH;
      2'd1:    pre_max = `ACQFL_PRE_MAX_2CH;
      2'd2:    pre_max = `ACQFL_PRE_MAX_4CH;
      default: pre_max = `ACQFL_PRE_MAX_8CH;
    endcase
  end

  // Record max depends on channels; mins and post max do not
  assign cfg_ok = streaming_single_mode ?
    (len_ok(pre_event_length, `ACQFL_MIN_PRE, pre_max) &&
     len_ok(segment_length, `ACQFL_MIN_SEG, `ACQFL_MAX_STREAM)) :
    (len_ok(record_length, `ACQFL_MIN_RECORD, max_record) &&
     len_ok(post_event_length, `ACQFL_MIN_POST, `ACQFL_MAX_STREAM) &&
     (post_event_length < record_length));

  // ---------------------------------------------------------------------
  // Sample FIFO in on-board memory
  // ---------------------------------------------------------------------
  reg  [MEM_AW:0]   wr_ptr;
  reg  [MEM_AW:0]   rd_ptr;
  wire [MEM_AW:0]   fill = wr_ptr - rd_ptr;
  wire              full = fill[MEM_AW];
  wire              empty = (fill == {(MEM_AW+1){1'b0}});
  reg               out_valid;
  reg               in_flight;
  wire              pop;
  wire              push;
  wire [15:0]       rd_word;
  wire              host_room = (card_bytes != 64'h0);
  wire              acq_end;

  // Whole memory is the FIFO in every mode
  assign o_smp_ready = o_running && !full;
  assign push = i_smp_valid && o_smp_ready;
  assign o_dma_valid = out_valid;
  // One word in flight at a time, so card bytes are never overspent
  assign pop = !empty && host_room && !out_valid && !in_flight;

  acqfl_sample_mem #(
    .AW (MEM_AW),
    .DW (16)
  ) u_mem (
    .i_ref_clk (i_ref_clk),
    .i_wr_en   (push),
    .i_wr_addr (wr_ptr[MEM_AW-1:0]),
    .i_wr_data (i_smp_data),
    .i_rd_addr (rd_ptr[MEM_AW-1:0]),
    .o_rd_data (rd_word)
  );

  // Record ends after record length, or segments when count is set
  assign acq_end = streaming_single_mode ?
    ((segment_count != 64'h0) && (seg_done == segment_count)) :
    (done_samples == record_length);

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr       <= {(MEM_AW+1){1'b0}};
      rd_ptr       <= {(MEM_AW+1){1'b0}};
      out_valid    <= 1'b0;
      in_flight    <= 1'b0;
      o_dma_data   <= 16'h0;
      o_running    <= 1'b0;
      o_cfg_error  <= 1'b0;
      o_overrun    <= 1'b0;
      done_samples <= 64'h0;
      seg_samples  <= 64'h0;
      seg_done     <= 64'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      // Memory read data is registered, so the word lands an edge later
      in_flight <= pop;
      if (in_flight) begin
        out_valid  <= 1'b1;
        o_dma_data <= rd_word;
      end else if (i_dma_ready) begin
        out_valid <= 1'b0;
      end
      if (o_running && i_smp_valid && full) begin
        o_overrun <= 1'b1;
      end
      if (i_start && !o_running) begin
        o_cfg_error  <= !cfg_ok;
        o_running    <= cfg_ok;
        o_overrun    <= 1'b0;
        done_samples <= 64'h0;
        seg_samples  <= 64'h0;
        seg_done     <= 64'h0;
      end else if (o_running) begin
        if (i_stop || acq_end) begin
          o_running <= 1'b0;
        end else if (push) begin
          done_samples <= done_samples + 64'h1;
          if (seg_samples + 64'h1 == segment_length) begin
            seg_samples <= 64'h0;
            seg_done    <= seg_done + 64'h1;
          end else begin
            seg_samples <= seg_samples + 64'h1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Host buffer handshake counters
  // ---------------------------------------------------------------------
  wire        rel_wr = i_reg_wr && (i_reg_idx == `ACQFL_IDX_CARD_RELEASE);
  wire [63:0] rel_amt = (i_reg_wdata > host_avail_byte_count) ?
                        host_avail_byte_count : i_reg_wdata;
  wire        moved = o_dma_valid && i_dma_ready;
  wire [63:0] word_bytes = `ACQFL_BYTES_PER_SAMPLE;
  wire [63:0] next_index_raw = host_avail_byte_index + rel_amt;
  reg  [63:0] next_index;

  always @* begin
    // Available region may straddle the buffer end
    if (next_index_raw >= buf_len) begin
      next_index = next_index_raw - buf_len;
    end else begin
      next_index = next_index_raw;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      host_avail_byte_count <= 64'h0;
      host_avail_byte_index <= 64'h0;
      card_bytes            <= 64'h0;
    end else if (i_start && !o_running) begin
      host_avail_byte_count <= 64'h0;
      host_avail_byte_index <= 64'h0;
      card_bytes            <= buf_len;
    end else begin
      // One counter per owner; bytes pass from card to user and back
      host_avail_byte_count <= host_avail_byte_count - (rel_wr ? rel_amt :
                               64'h0) + (moved ? word_bytes : 64'h0);
      card_bytes <= card_bytes + (rel_wr ? rel_amt : 64'h0) -
                    (moved ? word_bytes : 64'h0);
      if (rel_wr) begin
        host_avail_byte_index <= next_index;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Fill level
  // ---------------------------------------------------------------------
  // Only the top bits of the fill count are visible, so sixteenths
  wire [`ACQFL_FILL_SIXTEENTHS:0] fill_16 =
    fill[MEM_AW:MEM_AW-`ACQFL_FILL_SIXTEENTHS];
  wire [31:0] fifo_fill_permille = (fill_16[`ACQFL_FILL_SIXTEENTHS]) ?
    {22'h0, `ACQFL_PERMILLE_FULL} :
    {22'h0, 6'h0, fill_16[3:0]} * {22'h0, `ACQFL_PERMILLE_STEP};

  // ---------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      record_length         <= 64'h0;
      post_event_length     <= 64'h0;
      pre_event_length      <= 64'h0;
      segment_length        <= 64'h0;
      segment_count         <= 64'h0;
      buf_len               <= 64'h0;
      streaming_single_mode <= 1'b0;
      to_device             <= 1'b0;
      ch_log2               <= 2'd0;
    end else if (i_reg_wr && !o_running) begin
      // Setup is frozen while running
      if (i_reg_idx == `ACQFL_IDX_RECORD_LEN) begin
        record_length <= i_reg_wdata;
      end else if (i_reg_idx == `ACQFL_IDX_POST_LEN) begin
        post_event_length <= i_reg_wdata;
      end else if (i_reg_idx == `ACQFL_IDX_PRE_LEN) begin
        pre_event_length <= i_reg_wdata;
      end else if (i_reg_idx == `ACQFL_IDX_SEG_LEN) begin
        segment_length <= i_reg_wdata;
      end else if (i_reg_idx == `ACQFL_IDX_SEG_COUNT) begin
        segment_count <= i_reg_wdata;
      end else if (i_reg_idx == `ACQFL_IDX_BUF_LEN) begin
        buf_len <= i_reg_wdata;
      end else if (i_reg_idx == `ACQFL_IDX_CONFIG) begin
        streaming_single_mode <= i_reg_wdata[`ACQFL_CFG_STREAM_BIT];
        to_device <= i_reg_wdata[`ACQFL_CFG_TO_DEV_BIT];
        ch_log2 <= i_reg_wdata[`ACQFL_CFG_CH_MSB:`ACQFL_CFG_CH_LSB];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata  <= 64'h0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd) begin
        o_reg_rdata <= o_reg_rdata;
      end else if (i_reg_idx == `ACQFL_IDX_AVAIL_COUNT) begin
        o_reg_rdata <= host_avail_byte_count;
      end else if (i_reg_idx == `ACQFL_IDX_AVAIL_INDEX) begin
        o_reg_rdata <= host_avail_byte_index;
      end else if (i_reg_idx == `ACQFL_IDX_FILL_PERMILLE) begin
        o_reg_rdata <= {32'h0, fifo_fill_permille};
      end else if (i_reg_idx == `ACQFL_IDX_RECORD_LEN) begin
        o_reg_rdata <= record_length;
      end else if (i_reg_idx == `ACQFL_IDX_POST_LEN) begin
        o_reg_rdata <= post_event_length;
      end else if (i_reg_idx == `ACQFL_IDX_PRE_LEN) begin
        // Memory mode reports the derived pre-event length
        o_reg_rdata <= streaming_single_mode ? pre_event_length :
                       derived_pre;
      end else if (i_reg_idx == `ACQFL_IDX_SEG_LEN) begin
        o_reg_rdata <= segment_length;
      end else if (i_reg_idx == `ACQFL_IDX_SEG_COUNT) begin
        o_reg_rdata <= segment_count;
      end else if (i_reg_idx == `ACQFL_IDX_BUF_LEN) begin
        o_reg_rdata <= buf_len;
      end else if (i_reg_idx == `ACQFL_IDX_CONFIG) begin
        o_reg_rdata <= {58'h0, ch_log2, 2'b00, to_device,
                        streaming_single_mode};
      end else if (i_reg_idx == `ACQFL_IDX_STATUS) begin
        o_reg_rdata <= {61'h0, o_overrun, o_cfg_error, o_running};
      end else begin
        o_reg_rdata <= 64'h0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- verif/acqfl_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Port checks
// ---------------------------------------------------------------
module acqfl_core_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_reg_rd,
  input wire logic        o_reg_rvalid,
  input wire logic        i_start,
  input wire logic        i_smp_valid,
  input wire logic        o_smp_ready,
  input wire logic        o_dma_valid,
  input wire logic [15:0] o_dma_data,
  input wire logic        i_dma_ready,
  input wire logic        o_running,
  input wire logic        o_cfg_error,
  input wire logic        o_overrun
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read answer missing");
  chk_rd_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without request");
  chk_run_cause: assert property ($rose(o_running) |-> $past(i_start))
    else $error("run began without start");
  chk_ready_gate: assert property (o_smp_ready |-> o_running)
    else $error("samples taken while idle");
  chk_dma_hold: assert property (
    o_dma_valid && !i_dma_ready |=> o_dma_valid && $stable(o_dma_data))
    else $error("dma word dropped or changed while stalled");
  chk_ovr_clear: assert property (i_start && !o_running |=> !o_overrun)
    else $error("overrun not cleared by start");
  chk_ovr_cause: assert property (
    $rose(o_overrun) |-> $past(i_smp_valid && !o_smp_ready))
    else $error("overrun without refused sample");
  chk_err_blocks: assert property (o_cfg_error |-> !o_running)
    else $error("running with bad settings");
  chk_err_sticky: assert property (
    o_cfg_error && !i_start |=> o_cfg_error)
    else $error("error flag lost before next start");

  cp_run: cover property ($rose(o_running));
  cp_err: cover property ($rose(o_cfg_error));
  cp_stall: cover property (o_dma_valid && !i_dma_ready ##1 i_dma_ready);
  cp_ovr: cover property ($rose(o_overrun));
endmodule

bind acqfl_core acqfl_core_chk u_chk (
  .i_ref_clk   (i_ref_clk),
  .i_rst       (i_rst),
  .i_reg_rd    (i_reg_rd),
  .o_reg_rvalid(o_reg_rvalid),
  .i_start     (i_start),
  .i_smp_valid (i_smp_valid),
  .o_smp_ready (o_smp_ready),
  .o_dma_valid (o_dma_valid),
  .o_dma_data  (o_dma_data),
  .i_dma_ready (i_dma_ready),
  .o_running   (o_running),
  .o_cfg_error (o_cfg_error),
  .o_overrun   (o_overrun)
);
`default_nettype wire

// ---- verif/acqfl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Host buffer side
// ---------------------------------------------------------------
module acqfl_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output logic      o_dma_ready
);
  // Random back-pressure so both quick and slow hosts are seen
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dma_ready <= 1'b0;
    end else begin
      o_dma_ready <= ($urandom_range(3) != 0);
    end
  end
endmodule
`default_nettype wire

// ---- verif/acquisition_fifo_length_and_handshake_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  n_checks++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); \
  end

module acquisition_fifo_length_and_handshake_test;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [15:0] i_reg_idx = 16'h0000;
  logic [63:0] i_reg_wdata = 64'h0;
  logic        i_start = 1'b0;
  logic        i_stop = 1'b0;
  logic        i_smp_valid = 1'b0;
  logic [15:0] i_smp_data = 16'h0000;
  logic        i_dma_ready;
  logic [63:0] o_reg_rdata;
  logic        o_reg_rvalid;
  logic        o_smp_ready;
  logic        o_dma_valid;
  logic [15:0] o_dma_data;
  logic        o_running;
  logic        o_cfg_error;
  logic        o_overrun;
  logic [15:0] q[$];
  logic [15:0] exp_w;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          c;

  always #2.5 i_ref_clk = ~i_ref_clk;

  // Small memory keeps the record-length limits reachable
  acqfl_core #(.MEM_AW(10), .MEM_SAMPLES(64'h400)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_idx(i_reg_idx),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_start(i_start), .i_stop(i_stop),
    .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
    .o_smp_ready(o_smp_ready), .o_dma_valid(o_dma_valid),
    .o_dma_data(o_dma_data), .i_dma_ready(i_dma_ready),
    .o_running(o_running), .o_cfg_error(o_cfg_error),
    .o_overrun(o_overrun));

  acqfl_host_model u_host (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .o_dma_ready(i_dma_ready));

  // ---------------------------------------------------------------
  // Sample order through the FIFO, and the hang guard
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    cyc++;
    if (i_smp_valid && o_smp_ready) q.push_back(i_smp_data);
    if (o_dma_valid && i_dma_ready) begin
      exp_w = q.pop_front();
      `CHK(o_dma_data, exp_w)
    end
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  function automatic logic [63:0] pmax(input int ch);
    pmax = (64'h2000 >> ch) - (ch == 0 ? 16 : ch == 1 ? 8 : 4);
  endfunction

  // Fill permille of a 1024-word FIFO holding n words, in sixteenths
  function automatic logic [63:0] pml(input int n);
    int s;
    s = n * 32'h10 / 32'h400;
    pml = (s >= 32'h10) ? 64'h3e8 : 64'(s * 32'h3f);
  endfunction

  task automatic wr(input logic [15:0] idx, input logic [63:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_idx <= idx;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic poll(input logic [15:0] idx, input logic [63:0] want);
    logic [63:0] d;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b1;
      i_reg_idx <= idx;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
      @(posedge i_ref_clk);
      d = o_reg_rdata;
      if (d === want) break;
    end
    `CHK(d, want)
  endtask

  task automatic setup(input logic [63:0] cf, rec, post, pre, seg, cnt);
    wr(16'h0105, cf);
    wr(16'h0100, rec);
    wr(16'h0101, post);
    wr(16'h0102, pre);
    wr(16'h0103, seg);
    wr(16'h0104, cnt);
    wr(16'h0106, 64'h10);
  endtask

  task automatic go(input logic ok);
    @(posedge i_ref_clk);
    i_start <= 1'b1;
    @(posedge i_ref_clk);
    i_start <= 1'b0;
    @(posedge i_ref_clk);
    `CHK(o_running, ok)
    `CHK(o_cfg_error, !ok)
  endtask

  task automatic halt(input logic s);
    @(posedge i_ref_clk);
    i_stop <= s;
    @(posedge i_ref_clk);
    i_stop <= 1'b0;
    for (int k = 0; k < 40 && o_running; k++) @(posedge i_ref_clk);
    `CHK(o_running, 1'b0)
  endtask

  task automatic feed(input int n);
    int k;
    k = 0;
    @(posedge i_ref_clk);
    i_smp_valid <= 1'b1;
    i_smp_data <= 16'($urandom);
    while (k < n) begin
      @(posedge i_ref_clk);
      if (o_smp_ready) begin
        k++;
        i_smp_data <= 16'($urandom);
      end
    end
    i_smp_valid <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h892ed8d8));
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (c = 0; c < 4; c++) begin
      setup(64'h1 | (c << 4), 8, 4, pmax(c) + 4, 8, 0);
      go(1'b0);
      setup(64'h1 | (c << 4), 8, 4, pmax(c), 8, 0);
      go(1'b1);
      halt(1'b1);
    end
    setup(64'h1, 8, 4, 64'h6, 8, 0);
    go(1'b0);
    setup(64'h1, 8, 4, 64'h0, 8, 0);
    go(1'b0);
    setup(64'h1, 8, 4, 4, 4, 0);
    go(1'b0);
    setup(64'h1, 8, 4, 4, 64'h2_0000_0000, 0);
    go(1'b0);
    setup(64'h30, 64'h84, 4, 4, 8, 0);
    go(1'b0);
    setup(64'h0, 64'ha, 4, 4, 8, 0);
    go(1'b0);
    // Memory run: pre-event comes from record and post
    setup(64'h0, 8, 4, 64'h64, 8, 0);
    poll(16'h0102, 64'h4);
    go(1'b1);
    feed(8);
    halt(1'b0);
    poll(16'h00c8, 64'h10);
    // Streaming handshake with wrap at the buffer end
    setup(64'h1, 8, 4, 4, 8, 2);
    go(1'b1);
    poll(16'h00c8, 64'h0);
    poll(16'h00c9, 64'h0);
    wr(16'h0103, 64'h40);
    poll(16'h0103, 64'h8);
    feed(16);
    poll(16'h00c8, 64'h10);
    halt(1'b0);
    wr(16'h00ca, 64'h6);
    poll(16'h00c9, 64'h6);
    poll(16'h00c8, 64'h10);
    wr(16'h00ca, 64'ha);
    poll(16'h00c9, 64'h0);
    poll(16'h00c8, 64'h10);
    wr(16'h00ca, 64'h14);
    poll(16'h00c8, 64'h0);
    poll(16'h00c9, 64'h0);
    poll(16'h00cb, 64'h0);
    poll(16'h0050, 64'h0);
    `CHK(q.size(), 0)
    // Flood the FIFO once the host buffer is used up
    setup(64'h3, 8, 4, 4, 8, 0);
    poll(16'h0105, 64'h3);
    go(1'b1);
    feed(520);
    poll(16'h00cb, pml(512));
    feed(512);
    poll(16'h00cb, pml(1024));
    @(posedge i_ref_clk);
    i_smp_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_smp_valid <= 1'b0;
    @(posedge i_ref_clk);
    `CHK(o_overrun, 1'b1)
    poll(16'h0107, 64'h5);
    // Reset in mid-run drops every stored word
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    q.delete();
    @(posedge i_ref_clk);
    `CHK(o_running, 1'b0)
    `CHK(o_overrun, 1'b0)
    `CHK(o_dma_valid, 1'b0)
    poll(16'h00cb, pml(0));
    poll(16'h00c8, 64'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
